// ===== hw/cht_regs.svh
`ifndef CHT_REGS_SVH
`define CHT_REGS_SVH
// Register indices; byte address is four times the index
`define CHT_IDX_OPT 6'h01
`define CHT_IDX_CUR 6'h02
`define CHT_IDX_VLIM 6'h04
`define CHT_IDX_DCLIM 6'h0E
`define CHT_IDX_FAULT 6'h20
`define CHT_IDX_HST 6'h22
`define CHT_IDX_HCFG 6'h23
`define CHT_IDX_CMP 6'h30
`define CHT_IDX_MON 6'h31
`define CHT_IDX_PROT 6'h32
`define CHT_IDX_PEAK 6'h33
`define CHT_IDX_OVLD 6'h37
`define CHT_IDX_HEN 6'h38
`define CHT_IDX_THR 6'h3B
`define CHT_IDX_DGL 6'h3C
// Field positions
`define CHT_OPT_LP 7
`define CHT_FAULT_SOVP 4
`define CHT_HCFG_EXT 6
`define CHT_HCFG_HOLD 3
`define CHT_MON_SYS 5
`define CHT_PROT_OC2X 2
// Reset value and low power comparator code
`define CHT_OPT_RST 8'hE0
`define CHT_CMP_LP 3'h4
// Timing
`define CHT_CLK_NS 50
`define CHT_MS_NS 1000000
`define CHT_INPUT_OVERCURRENT_MS 300
`define CHT_WD0_S 40
`define CHT_WD1_S 80
`define CHT_WD2_S 175
`define CHT_DG_UNIT_CYC 20
`endif

// ===== hw/cht_pkg.sv
package cht_pkg;
  // Monitor inputs from the analog front end, asynchronous to sys_clk
  typedef struct packed {
    logic surge_discharge;
    logic sys_drop;
    logic load_high;
    logic peak_raw;
    logic avg_raw;
    logic discharge_raw;
    logic sys_low_raw;
    logic charger_ok;
    logic cell_config_pin;
    logic comparator_output;
    logic input_droop_raw;
    logic vap_active;
    logic cmp_in_above;
    logic input_overvoltage;
    logic oc_133;
    logic oc_2x;
    logic system_overvoltage;
    logic adapter_present;
  } cht_mon_s;
  typedef struct packed {
    logic converter_en;
    logic charge_en;
    logic overload_sel;
    logic charger_ok;
  } cht_ctl_s;
  typedef enum logic [1:0] {HOT_IDLE, HOT_PULSE, HOT_EXT, HOT_HOLD} cht_hot_e;
  typedef enum logic [1:0] {PP_IDLE, PP_OVLD, PP_DC} cht_pp_e;
endpackage

// ===== hw/cht_top.sv
// The placing of the registers and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "cht_regs.svh"
module cht_top #(
  parameter int MS_CYC = `CHT_MS_NS / `CHT_CLK_NS
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire cht_pkg::cht_mon_s monitors,
  output logic processor_hot_n,
  output cht_pkg::cht_ctl_s ctl,
  output logic [4:0] overload_current_limit,
  output logic [7:0] dc_current_limit,
  output logic [7:0] charge_current_setting,
  output logic [7:0] charge_voltage_limit,
  output logic [7:0] threshold_cfg,
  output logic [7:0] comparator_cfg
);
  localparam int MSW = $clog2(MS_CYC + 1);

  function automatic logic [5:0] reg_idx(input logic [7:0] a);
    return a[7:2];
  endfunction

  function automatic logic mapped(input logic [5:0] i);
    unique case (i)
      `CHT_IDX_OPT, `CHT_IDX_CUR, `CHT_IDX_VLIM, `CHT_IDX_DCLIM,
      `CHT_IDX_FAULT, `CHT_IDX_HST, `CHT_IDX_HCFG, `CHT_IDX_CMP,
      `CHT_IDX_MON, `CHT_IDX_PROT, `CHT_IDX_PEAK, `CHT_IDX_OVLD,
      `CHT_IDX_HEN, `CHT_IDX_THR, `CHT_IDX_DGL: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and edges
  cht_pkg::cht_mon_s m1_q, m2_q, mp_q;
  // Pins are asynchronous to sys_clk
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      m1_q <= '0;
      m2_q <= '0;
      mp_q <= '0;
    end else begin
      m1_q <= monitors;
      m2_q <= m1_q;
      mp_q <= m2_q;
    end
  end

  // Millisecond tick shared by all slow timers
  logic [MSW-1:0] ms_cnt_q;
  logic ms_tick;
  assign ms_tick = (ms_cnt_q == MSW'(MS_CYC - 1));
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) ms_cnt_q <= '0;
    else if (ms_tick) ms_cnt_q <= '0;
    else ms_cnt_q <= ms_cnt_q + 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // Register file and AXI4-Lite slave
  logic [7:0] opt_q, cur_q, vlim_q, dclim_q, cmp_q, mon_q, prot_q;
  logic [7:0] peak_q, ovld_q, hen_q, thr_q, dgl_q, hcfg_q;
  logic sovp_q, hold_q;
  logic [8:0] st_q;
  logic wr_fire, rd_fire, we, wd_expire, hold_set;
  logic [5:0] widx, ridx;
  logic [7:0] wb;
  logic [8:0] ev_act, ev_fire;
  logic [31:0] rd_data;

  assign wr_fire = s_axi_awready & s_axi_awvalid & s_axi_wvalid;
  assign rd_fire = s_axi_arready & s_axi_arvalid;
  assign widx = reg_idx(s_axi_awaddr);
  assign ridx = reg_idx(s_axi_araddr);
  assign wb = s_axi_wdata[7:0];
  assign we = wr_fire & s_axi_wstrb[0] & mapped(widx);

  // Take address and data together, answer one cycle later
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && s_axi_wvalid && !s_axi_awready
          && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(widx) ? 2'h0 : 2'h2;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read data mux; reserved bits read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    unique case (ridx)
      `CHT_IDX_OPT: rd_data[7:0] = opt_q;
      `CHT_IDX_CUR: rd_data[7:0] = cur_q;
      `CHT_IDX_VLIM: rd_data[7:0] = vlim_q;
      `CHT_IDX_DCLIM: rd_data[7:0] = dclim_q;
      `CHT_IDX_FAULT: rd_data[`CHT_FAULT_SOVP] = sovp_q;
      `CHT_IDX_HST: rd_data[7:0] = st_q[7:0];
      `CHT_IDX_HCFG: rd_data[7:0] = {hcfg_q[7:4], hold_q, hcfg_q[2:1],
                                     st_q[8]};
      `CHT_IDX_CMP: rd_data[7:0] = cmp_q;
      `CHT_IDX_MON: rd_data[7:0] = mon_q;
      `CHT_IDX_PROT: rd_data[7:0] = prot_q;
      `CHT_IDX_PEAK: rd_data[7:0] = peak_q;
      `CHT_IDX_OVLD: rd_data[7:0] = ovld_q;
      `CHT_IDX_HEN: rd_data[7:0] = hen_q;
      `CHT_IDX_THR: rd_data[7:0] = thr_q;
      `CHT_IDX_DGL: rd_data[7:0] = dgl_q;
      default: rd_data = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_data;
        s_axi_rresp <= mapped(ridx) ? 2'h0 : 2'h2;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Plain configuration registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      opt_q <= `CHT_OPT_RST;
      vlim_q <= 8'h00;
      dclim_q <= 8'h00;
      cmp_q <= 8'h00;
      mon_q <= 8'h00;
      prot_q <= 8'h00;
      peak_q <= 8'h00;
      ovld_q <= 8'h00;
      hen_q <= 8'h00;
      thr_q <= 8'h00;
      dgl_q <= 8'h00;
      hcfg_q <= 8'h00;
    end else if (we) begin
      unique case (widx)
        `CHT_IDX_OPT: opt_q <= wb;
        `CHT_IDX_VLIM: vlim_q <= wb;
        `CHT_IDX_DCLIM: dclim_q <= wb;
        `CHT_IDX_CMP: cmp_q <= wb;
        `CHT_IDX_MON: mon_q <= wb;
        `CHT_IDX_PROT: prot_q <= wb;
        `CHT_IDX_PEAK: peak_q <= wb;
        `CHT_IDX_OVLD: ovld_q <= wb;
        `CHT_IDX_HEN: hen_q <= wb;
        `CHT_IDX_THR: thr_q <= wb;
        `CHT_IDX_DGL: dgl_q <= wb;
        `CHT_IDX_HCFG: hcfg_q <= {wb[7:4], 1'b0, wb[2:0]};
        default: ;
      endcase
    end
  end

  // Charge current: watchdog expiry zeroes it, a write in that cycle wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cur_q <= 8'h00;
    else if (we && widx == `CHT_IDX_CUR) cur_q <= wb;
    else if (wd_expire) cur_q <= 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // Event detection
  logic [3:0] dg_raw, dg_q;
  assign dg_raw = {m2_q.comparator_output, m2_q.discharge_raw,
                   m2_q.avg_raw, m2_q.peak_raw};

  // Deglitch: output follows input only after it stays put long enough
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : gen_dg
      logic [7:0] cnt_q;
      logic [7:0] lim;
      assign lim = 8'(dgl_q[2*g +: 2] * `CHT_DG_UNIT_CYC);
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cnt_q <= 8'h00;
          dg_q[g] <= 1'b0;
        end else if (dg_raw[g] == dg_q[g]) begin
          cnt_q <= 8'h00;
        end else if (cnt_q >= lim) begin
          dg_q[g] <= dg_raw[g];
          cnt_q <= 8'h00;
        end else begin
          cnt_q <= cnt_q + 1'b1;
        end
      end
    end
  endgenerate

  logic cmp_prev_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) cmp_prev_q <= 1'b0;
    else cmp_prev_q <= dg_q[3];
  end

  // Bits 0..7 follow the event enable register, bit 8 is VAP exit
  assign ev_act[0] = dg_q[0];
  assign ev_act[1] = dg_q[1];
  assign ev_act[2] = dg_q[2];
  assign ev_act[3] = m2_q.sys_low_raw;
  assign ev_act[4] = mp_q.charger_ok & ~m2_q.charger_ok;
  assign ev_act[5] = mp_q.cell_config_pin & ~m2_q.cell_config_pin;
  assign ev_act[6] = cmp_prev_q & ~dg_q[3];
  assign ev_act[7] = m2_q.input_droop_raw;
  assign ev_act[8] = mp_q.vap_active & ~m2_q.vap_active;
  assign ev_fire = ev_act & {1'b1, hen_q};

  // Low power throttle: comparator above its fixed level
  logic lp_fire;
  assign lp_fire = opt_q[`CHT_OPT_LP] && hen_q == 8'h00
                   && cmp_q[6:4] == `CHT_CMP_LP
                   && mon_q[`CHT_MON_SYS] && m2_q.cmp_in_above;

  ////////////////////////////////////////////////////////////////////////
  // Throttle pulse sequencer
  cht_pkg::cht_hot_e hot_q, hot_d;
  logic [3:0] pw_q, pw_ms;
  logic any_fire, any_act;
  assign any_fire = (|ev_fire) | lp_fire;
  assign any_act = (|(ev_act[7:0] & hen_q & ~8'h30)) | lp_fire;
  assign pw_ms = 4'h1 << hcfg_q[5:4];
  assign hold_set = any_fire & (hcfg_q[`CHT_HCFG_EXT]
                                | ev_fire[7] | ev_fire[8]);

  always_comb begin
    hot_d = hot_q;
    unique case (hot_q)
      cht_pkg::HOT_IDLE: if (any_fire) hot_d = cht_pkg::HOT_PULSE;
      cht_pkg::HOT_PULSE: if (ms_tick && pw_q == 4'h0) begin
        if (hold_q) hot_d = cht_pkg::HOT_HOLD;
        else if (any_act) hot_d = cht_pkg::HOT_EXT;
        else hot_d = cht_pkg::HOT_IDLE;
      end
      cht_pkg::HOT_EXT: begin
        if (hold_q) hot_d = cht_pkg::HOT_HOLD;
        else if (!any_act) hot_d = cht_pkg::HOT_IDLE;
      end
      cht_pkg::HOT_HOLD: if (!hold_q) hot_d = cht_pkg::HOT_IDLE;
    endcase
  end

  // Width counts whole ms ticks plus one, so the pulse is never short
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hot_q <= cht_pkg::HOT_IDLE;
      pw_q <= 4'h0;
      processor_hot_n <= 1'b1;
    end else begin
      hot_q <= hot_d;
      processor_hot_n <= (hot_d == cht_pkg::HOT_IDLE);
      if (hot_q == cht_pkg::HOT_IDLE) pw_q <= pw_ms;
      else if (ms_tick && pw_q != 4'h0) pw_q <= pw_q - 1'b1;
    end
  end

  // Hold flag: host writes zero to release, a new trigger wins
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) hold_q <= 1'b0;
    else if (hold_set) hold_q <= 1'b1;
    else if (we && widx == `CHT_IDX_HCFG && !wb[`CHT_HCFG_HOLD])
      hold_q <= 1'b0;
  end

  // Sticky status; a read clears only bits whose event has gone
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st_q <= 9'h000;
    end else begin
      for (int i = 0; i < 9; i++) begin
        if (ev_fire[i] || (i == 6 && lp_fire)) st_q[i] <= 1'b1;
        else if (rd_fire && !ev_act[i]
                 && ((i < 8 && ridx == `CHT_IDX_HST)
                     || (i == 8 && ridx == `CHT_IDX_HCFG)))
          st_q[i] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Two-level input limit sequencer
  cht_pkg::cht_pp_e pp_q;
  logic [5:0] pp_cnt_q, overload_time, peak_cycle_time;
  logic pp_en, pp_trig;
  always_comb begin
    unique case (peak_q[7:6])
      2'h0: overload_time = 6'd1;
      2'h1: overload_time = 6'd2;
      2'h2: overload_time = 6'd10;
      2'h3: overload_time = 6'd20;
    endcase
    unique case (peak_q[1:0])
      2'h0: peak_cycle_time = 6'd5;
      2'h1: peak_cycle_time = 6'd10;
      2'h2: peak_cycle_time = 6'd20;
      2'h3: peak_cycle_time = 6'd40;
    endcase
  end
  assign pp_en = |peak_q[5:4];
  assign pp_trig = (peak_q[5] & m2_q.surge_discharge)
                   | (peak_q[4] & m2_q.sys_drop);

  // Counter runs from cycle start in ms; equal times never leave overload
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pp_q <= cht_pkg::PP_IDLE;
      pp_cnt_q <= 6'h00;
    end else if (!pp_en) begin
      pp_q <= cht_pkg::PP_IDLE;
      pp_cnt_q <= 6'h00;
    end else begin
      unique case (pp_q)
        cht_pkg::PP_IDLE: if (pp_trig) begin
          pp_q <= cht_pkg::PP_OVLD;
          pp_cnt_q <= 6'h00;
        end
        cht_pkg::PP_OVLD: if (ms_tick) begin
          pp_cnt_q <= pp_cnt_q + 1'b1;
          if (pp_cnt_q + 6'h01 >= overload_time && overload_time != peak_cycle_time)
            pp_q <= cht_pkg::PP_DC;
        end
        cht_pkg::PP_DC: if (ms_tick) begin
          pp_cnt_q <= pp_cnt_q + 1'b1;
          if (pp_cnt_q + 6'h01 >= peak_cycle_time) begin
            pp_cnt_q <= 6'h00;
            pp_q <= m2_q.load_high ? cht_pkg::PP_OVLD
                                   : cht_pkg::PP_IDLE;
          end
        end
        default: pp_q <= cht_pkg::PP_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge watchdog
  logic [17:0] wd_q, wd_lim;
  logic wd_susp_q, wd_kick;
  always_comb begin
    unique case (opt_q[6:5])
      2'h1: wd_lim = 18'(`CHT_WD0_S * 1000);
      2'h2: wd_lim = 18'(`CHT_WD1_S * 1000);
      default: wd_lim = 18'(`CHT_WD2_S * 1000);
    endcase
  end
  assign wd_kick = we && (widx == `CHT_IDX_CUR || widx == `CHT_IDX_VLIM);
  assign wd_expire = opt_q[6:5] != 2'h0 && ms_tick && wd_q + 18'h1 >= wd_lim
                     && !wd_kick;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wd_q <= '0;
      wd_susp_q <= 1'b0;
    end else if (wd_kick) begin
      wd_q <= '0;
      wd_susp_q <= 1'b0;
    end else if (opt_q[6:5] == 2'h0) begin
      wd_q <= '0;
      wd_susp_q <= 1'b0;
    end else if (wd_expire) begin
      wd_q <= '0;
      wd_susp_q <= 1'b1;
    end else if (ms_tick && !wd_susp_q) begin
      wd_q <= wd_q + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input and system protection
  logic [8:0] oc_q;
  logic oc_trip, oc_hold;
  assign oc_trip = prot_q[`CHT_PROT_OC2X] ? m2_q.oc_2x : m2_q.oc_133;
  assign oc_hold = oc_q != 9'h000;

  // Restart delay counted in ms ticks after the trip
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) oc_q <= 9'h000;
    else if (oc_trip && !oc_hold) oc_q <= 9'(`CHT_INPUT_OVERCURRENT_MS);
    else if (ms_tick && oc_hold) oc_q <= oc_q - 1'b1;
  end

  // System overvoltage latch; a new trip wins over the clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) sovp_q <= 1'b0;
    else if (m2_q.system_overvoltage) sovp_q <= 1'b1;
    else if ((we && widx == `CHT_IDX_FAULT && !wb[`CHT_FAULT_SOVP])
             || (m2_q.adapter_present && !mp_q.adapter_present))
      sovp_q <= 1'b0;
  end

  // Registered control outputs
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctl <= '0;
    end else begin
      ctl.charger_ok <= !m2_q.input_overvoltage;
      ctl.converter_en <= !m2_q.input_overvoltage && !oc_hold
                          && !oc_trip && !sovp_q;
      ctl.charge_en <= !m2_q.input_overvoltage && !oc_hold && !sovp_q
                       && pp_q == cht_pkg::PP_IDLE && !wd_susp_q;
      ctl.overload_sel <= (pp_q == cht_pkg::PP_OVLD);
    end
  end

  // Register values driven to the analog side
  assign overload_current_limit = ovld_q[7:3];
  assign dc_current_limit = dclim_q;
  assign charge_current_setting = cur_q;
  assign charge_voltage_limit = vlim_q;
  assign threshold_cfg = thr_q;
  assign comparator_cfg = cmp_q;
endmodule // cht_top

// ===== tb/cht_top_sva.sv
`timescale 1ns/1ps
module cht_top_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire cht_pkg::cht_mon_s monitors,
  input wire logic processor_hot_n,
  input wire cht_pkg::cht_ctl_s ctl
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic hold_q;
  // Remembers a VAP exit until software writes the throttle config
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst)
      hold_q <= 1'b0;
    else if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == 8'h8C)
      hold_q <= 1'b0;
    else if ($fell(monitors.vap_active))
      hold_q <= 1'b1;
  end
  //////////////////////////////////////////////////////////////////////
  property p_wr_resp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid |=> s_axi_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response lost");
  property p_rd_resp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("no read response");
  property p_vap_hot;
    $fell(monitors.vap_active) |-> ##[1:6] !processor_hot_n;
  endproperty
  a_vap_hot: assert property (p_vap_hot) else $error("VAP exit no throttle");
  property p_vap_hold;
    hold_q && $past(hold_q, 8) |-> !processor_hot_n;
  endproperty
  a_vap_hold: assert property (p_vap_hold) else $error("VAP hold dropped");
  property p_min_width;
    $fell(processor_hot_n) |-> (!processor_hot_n)[*8] ##12 !processor_hot_n;
  endproperty
  a_min_width: assert property (p_min_width) else $error("pulse too short");
  property p_ovp_off;
    monitors.input_overvoltage[*5] |-> !ctl.charger_ok && !ctl.converter_en;
  endproperty
  a_ovp_off: assert property (p_ovp_off) else $error("overvoltage ignored");
  property p_oc_off;
    (monitors.oc_133 && monitors.oc_2x)[*5] |-> !ctl.converter_en;
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("overcurrent ignored");
  property p_sovp_off;
    monitors.system_overvoltage[*5] |-> !ctl.converter_en;
  endproperty
  a_sovp_off: assert property (p_sovp_off) else $error("sys overvoltage ignored");
  property p_peak_nochg;
    ctl.overload_sel[*2] |-> !ctl.charge_en;
  endproperty
  a_peak_nochg: assert property (p_peak_nochg) else $error("charging in peak");
  // Main scenarios reached
  c_hot: cover property ($fell(processor_hot_n));
  c_conv_off: cover property ($fell(ctl.converter_en));
  c_peak: cover property ($rose(ctl.overload_sel));
endmodule // cht_top_chk
bind cht_top cht_top_chk i_cht_top_chk (.sys_clk, .rst, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .monitors,
  .processor_hot_n, .ctl);

// ===== tb/cht_cpu_model.sv
`timescale 1ns/1ps
module cht_cpu_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic processor_hot_n,
  output int low_len
);
  int run;
  // Length of the last finished throttle pulse, as the CPU sees it
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      run <= 0;
      low_len <= 0;
    end else if (!processor_hot_n) begin
      run <= run + 1;
    end else if (run != 0) begin
      low_len <= run;
      run <= 0;
    end
  end
endmodule // cht_cpu_model

// ===== tb/cht_top_tb.sv
`timescale 1ns/1ps
module cht_top_tb;
  localparam int MS = 20;
  localparam logic [1:0] OK = 2'h0;
  localparam logic [1:0] ERR = 2'h2;
  logic sys_clk, rst;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, processor_hot_n;
  cht_pkg::cht_mon_s monitors;
  cht_pkg::cht_ctl_s ctl;
  logic [4:0] overload_current_limit;
  logic [7:0] dc_current_limit, charge_current_setting, comparator_cfg;
  logic [7:0] charge_voltage_limit, threshold_cfg;
  int low_len, error_cnt, n_checks;
  cht_top #(.MS_CYC(MS)) i_cht_top (.sys_clk, .rst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .monitors, .processor_hot_n,
    .ctl, .overload_current_limit, .dc_current_limit, .charge_current_setting,
    .charge_voltage_limit, .threshold_cfg, .comparator_cfg);
  cht_cpu_model i_cht_cpu_model (.sys_clk, .rst, .processor_hot_n, .low_len);
  //////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Address and data go out together and are dropped once taken
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] r,
      logic [3:0] s = 4'hF);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge sys_clk);
    s_axi_bready <= 1'b0;
    chk("write response", {30'h0, r}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] r);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    s_axi_rready <= 1'b0;
    chk("read response", {30'h0, r}, {30'h0, s_axi_rresp});
    chk("read data", {24'h0, e}, s_axi_rdata);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Free-running 20 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  // Cuts a hang short; the whole sequence needs well under 20000 cycles
  initial begin
    #(20000 * 50);
    error_cnt++;
    complete_run();
  end
  // Register traffic and pin events in sequence
  initial begin
    rst = 1'b1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, error_cnt, n_checks} = '0;
    monitors = '0;
    monitors.charger_ok = 1'b1;
    monitors.cell_config_pin = 1'b1;
    monitors.comparator_output = 1'b1;
    monitors.adapter_present = 1'b1;
    wt(5);
    rst <= 1'b0;
    rd(8'h04, 8'hE0, OK);
    rd(8'h0C, 8'h00, ERR);
    wr(8'h0C, 8'h55, ERR);
    wr(8'hDC, 8'hA8, OK);
    wr(8'h38, 8'h5A, OK);
    wr(8'h08, 8'h40, OK);
    wr(8'h08, 8'hFF, OK, 4'h0);
    chk("overload limit", 32'h15, overload_current_limit);
    chk("dc limit", 32'h5A, dc_current_limit);
    chk("charge current", 32'h40, charge_current_setting);
    wr(8'h10, 8'hC3, OK);
    wr(8'hEC, 8'h3C, OK);
    chk("voltage limit", 32'hC3, charge_voltage_limit);
    chk("thresholds", 32'h3C, threshold_cfg);
    $display("test registers done");
    // VAP exit holds the throttle until the hold flag is written low
    monitors.vap_active <= 1'b1;
    wt(10);
    monitors.vap_active <= 1'b0;
    wt(400);
    chk("hot held", 32'h0, processor_hot_n);
    rd(8'h8C, 8'h09, OK);
    wr(8'h8C, 8'h00, OK);
    wt(10);
    chk("hot freed", 32'h1, processor_hot_n);
    rd(8'h8C, 8'h00, OK);
    $display("test vap exit done");
    // Disabled comparator edge is ignored, enabled one pulses 2 ms
    monitors.comparator_output <= 1'b0;
    wt(20);
    chk("gated hot", 32'h1, processor_hot_n);
    monitors.comparator_output <= 1'b1;
    wr(8'hE0, 8'h40, OK);
    wr(8'h8C, 8'h10, OK);
    monitors.comparator_output <= 1'b0;
    wt(100);
    chk("width", 32'h1, {31'h0, low_len >= 2 * MS && low_len <= 3 * MS + 4});
    rd(8'h88, 8'h40, OK);
    rd(8'h88, 8'h00, OK);
    monitors.comparator_output <= 1'b1;
    $display("test pulse done");
    // Level event stretches the pulse; status sticks while active
    wr(8'hE0, 8'h08, OK);
    wr(8'h8C, 8'h00, OK);
    monitors.sys_low_raw <= 1'b1;
    wt(150);
    chk("extended", 32'h0, processor_hot_n);
    rd(8'h88, 8'h08, OK);
    rd(8'h88, 8'h08, OK);
    monitors.sys_low_raw <= 1'b0;
    wt(30);
    chk("ext end", 32'h1, processor_hot_n);
    rd(8'h88, 8'h08, OK);
    rd(8'h88, 8'h00, OK);
    $display("test extension done");
    // Extension mode keeps the pin low after the event is gone
    wr(8'hE0, 8'h40, OK);
    wr(8'h8C, 8'h40, OK);
    monitors.comparator_output <= 1'b0;
    wt(200);
    chk("ext hold", 32'h0, processor_hot_n);
    wr(8'h8C, 8'h40, OK);
    wt(10);
    chk("ext clear", 32'h1, processor_hot_n);
    monitors.comparator_output <= 1'b1;
    wr(8'h8C, 8'h00, OK);
    $display("test extension mode done");
    // Low power throttle from the comparator input alone
    wr(8'hE0, 8'h00, OK);
    wr(8'hC0, 8'h40, OK);
    wr(8'hC4, 8'h20, OK);
    chk("comparator cfg", 32'h40, comparator_cfg);
    monitors.cmp_in_above <= 1'b1;
    wt(10);
    chk("low power hot", 32'h0, processor_hot_n);
    monitors.cmp_in_above <= 1'b0;
    wt(100);
    chk("low power end", 32'h1, processor_hot_n);
    $display("test low power done");
    // Peak power: 1 ms overload, 5 ms peak, no charging meanwhile
    wr(8'hCC, 8'h20, OK);
    monitors.surge_discharge <= 1'b1;
    wt(2);
    monitors.surge_discharge <= 1'b0;
    // Five edges after the trigger: no ms tick can have ended overload yet
    wt(3);
    chk("overload on", 32'h1, ctl.overload_sel);
    chk("charge off", 32'h0, ctl.charge_en);
    wt(55);
    chk("dc limit on", 32'h0, ctl.overload_sel);
    chk("charge still off", 32'h0, ctl.charge_en);
    wt(80);
    chk("charge back", 32'h1, ctl.charge_en);
    // Equal overload and peak times: the overload limit never lets go
    wr(8'hCC, 8'hA1, OK);
    monitors.surge_discharge <= 1'b1;
    wt(3);
    monitors.surge_discharge <= 1'b0;
    wt(300);
    chk("peak permanent", 32'h1, ctl.overload_sel);
    chk("charge held off", 32'h0, ctl.charge_en);
    wr(8'hCC, 8'h00, OK);
    $display("test peak power done");
    // Protection faults
    monitors.input_overvoltage <= 1'b1;
    wt(8);
    chk("ok low", 32'h0, {ctl.charger_ok, ctl.converter_en});
    monitors.input_overvoltage <= 1'b0;
    wt(8);
    chk("ok back", 32'h3, {ctl.charger_ok, ctl.converter_en});
    monitors.system_overvoltage <= 1'b1;
    wt(8);
    monitors.system_overvoltage <= 1'b0;
    wt(20);
    chk("latched off", 32'h0, ctl.converter_en);
    rd(8'h80, 8'h10, OK);
    wr(8'h80, 8'h00, OK);
    wt(8);
    chk("latch cleared", 32'h1, ctl.converter_en);
    monitors.oc_133 <= 1'b1;
    monitors.oc_2x <= 1'b1;
    wt(10);
    monitors.oc_133 <= 1'b0;
    monitors.oc_2x <= 1'b0;
    wt(290 * MS);
    chk("oc stopped", 32'h0, ctl.converter_en);
    wt(15 * MS);
    chk("oc restart", 32'h1, ctl.converter_en);
    $display("test protection done");
    complete_run();
  end
endmodule // cht_top_tb
